// File: src/mcp_pkg.sv
// Purpose: shared constants and state type for the motor serial config port
// Assumes: 29-bit control word, shifted MSB first
// Notes:   bit positions and pole codes match the control word layout
package mcp_pkg;

  // control word geometry
  localparam int unsigned WORD_W = 29;
  localparam int unsigned REF_W  = 18;
  localparam int unsigned CNT_W  = 6;

  // control word bit positions
  localparam int unsigned B_SLEEP_RUN  = 0;
  localparam int unsigned B_STEP_ONLY  = 1;
  localparam int unsigned B_BRAKE      = 2;
  localparam int unsigned B_ILIM_LO    = 3;
  localparam int unsigned B_ILIM_HI    = 4;
  localparam int unsigned B_SPEED_LO   = 5;
  localparam int unsigned B_SPEED_HI   = 18;
  localparam int unsigned B_FEEDBACK   = 19;
  localparam int unsigned B_POLE_A     = 20;
  localparam int unsigned B_POLE_B     = 21;
  localparam int unsigned B_DIAG_A     = 22;
  localparam int unsigned B_DIAG_B     = 23;
  localparam int unsigned B_EXT_REG    = 24;
  localparam int unsigned B_DIRECTION  = 25;
  localparam int unsigned B_WD_LO      = 26;
  localparam int unsigned B_WD_HI      = 27;
  localparam int unsigned B_GAIN       = 28;

  // speed reference: weight of bit 5 is 16, i.e. shift by four
  localparam int unsigned SPEED_SHIFT = 4;

  // commutation toggles per revolution (poles x 3), code {bit20,bit21}
  localparam logic [CNT_W-1:0] TOGGLES_P8  = 6'h18;
  localparam logic [CNT_W-1:0] TOGGLES_P4  = 6'h0C;
  localparam logic [CNT_W-1:0] TOGGLES_P16 = 6'h30;
  localparam logic [CNT_W-1:0] TOGGLES_P12 = 6'h24;

  // diagnostic multiplexer codes, {bit22,bit23}
  localparam logic [1:0] DIAG_REV_SPEED_SIGNAL  = 2'h0;
  localparam logic [1:0] DIAG_THERM = 2'h1;
  localparam logic [1:0] DIAG_SYNC  = 2'h2;
  localparam logic [1:0] DIAG_COMM  = 2'h3;

  // pin index inside the synchroniser vector
  localparam int unsigned PIN_N      = 8;
  localparam int unsigned P_SCLK     = 0;
  localparam int unsigned P_CS_N     = 1;
  localparam int unsigned P_SDI      = 2;
  localparam int unsigned P_UVLO     = 3;
  localparam int unsigned P_THERM    = 4;
  localparam int unsigned P_SECTOR   = 5;
  localparam int unsigned P_BEMF     = 6;
  localparam int unsigned P_SYNC     = 7;

  // whole block state
  typedef struct packed {
    logic [PIN_N-1:0]  sync1;
    logic [PIN_N-1:0]  sync2;
    logic [PIN_N-1:0]  prev;
    logic [WORD_W-1:0] shift;
    logic [WORD_W-1:0] word;
    logic [CNT_W-1:0]  comm_cnt;
    logic              comm_toggle;
    logic              rev_speed_signal_int;
    logic              rev_speed_signal;
    logic [REF_W-1:0]  ref_cnt;
    logic              ref_done;
    logic              init;
    logic              err_fast;
    logic              err_slow;
    logic              diag;
  } mcp_state_t;

  // synchronisers wake at the pins' idle levels (select high), so no
  // false select edge follows the release of reset
  localparam logic [PIN_N-1:0] PIN_IDLE = 8'h02;

  // value after reset: word cleared (sleep), speed loop held in init
  localparam mcp_state_t ST_RST = '{sync1: PIN_IDLE, sync2: PIN_IDLE,
                                    prev: PIN_IDLE, init: 1'b1,
                                    default: '0};

endpackage

// File: src/mcp_ctrl.sv
// Purpose: serial control port, control word decode and speed compare
// Assumes: serial clock far slower than I_SYS_CLK (8+ samples per period)
// Notes:   all pins but clock and reset are sampled through two flops before use
//          so a pin pulse shorter than one clock may be missed
// Operation
// - while select low, one bit per rising serial clock, bit 28 first
// - select rising ends the frame and loads the word into control
// - short frames leave the unprogrammed upper bits at zero
// - bit 0: zero sleeps, one runs
// - bit 1 set: commutation events ignored, start-up oscillator steps
// - bit 2 set commands dynamic braking
// - bits 3 and 4 pick the current limit, scaled by bit 28
// - bit 28 picks transconductance gain 500 or 250 mA/V
// - bits 5 to 18, active low, weights 16 up, sum to count
// - bit 19 picks internal revolution signal or external sector input
// - bits 20, 21 give pole count 8, 4, 16, 12
// - bits 22, 23 pick rev_speed_signal, thermal, sync or commutation toggle
// - thermal view: low while within limits, high after shutdown
// - bit 24 set disables internal regulation for external control
// - bit 25: clear forward, set reverse
// - bits 26, 27 pick watchdog charge current 10 to 40 uA
// - reset low clears the whole word, so the part sleeps
// - logic undervoltage clears the whole word, so the part sleeps
// - speed loop init holds from start-up until first too-fast error while running
// - speed loop init also holds while external regulation is chosen
// - rev_speed_signal falling before reference expires is too fast, after too slow
// - internal rev_speed_signal toggles every poles x 3 toggles, restarting reference
// - reference counter counts clocks up to the programmed total
`timescale 1ns/100ps
module mcp_ctrl
  import mcp_pkg::*;
#(
  parameter int unsigned P_WORD_W = 29
)
(
  // clock and reset
  input  wire logic       I_SYS_CLK,
  input  wire logic       I_RSTN,
  // serial port pins
  input  wire logic       I_SCLK,
  input  wire logic       I_CS_N,
  input  wire logic       I_SDI,
  // status pins from the analog side
  input  wire logic       I_UVLO,
  input  wire logic       I_THERMAL_SHUTDOWN,
  input  wire logic       I_SECTOR_DATA,
  input  wire logic       I_BEMF_EVENT,
  input  wire logic       I_SYNC,
  // decoded control
  output logic            O_RUN,
  output logic            O_STEP_ONLY,
  output logic            O_BRAKE,
  output logic [1:0]      O_CURRENT_LIMIT,
  output logic            O_GAIN_SELECT,
  output logic            O_FEEDBACK_SOURCE,
  output logic            O_EXTERNAL_REGULATION,
  output logic            O_DIRECTION,
  output logic [1:0]      O_WD_CURRENT,
  // speed loop
  output logic            O_SPEED_LOOP_INIT,
  output logic            O_ERROR_FAST,
  output logic            O_ERROR_SLOW,
  output logic            O_REV_SPEED_SIGNAL,
  output logic            O_COMMUTATION_TOGGLE,
  // diagnostic pin
  output logic            O_DIAG_OUT
);

  // the decode is fixed to the 29-bit layout
  if (P_WORD_W != WORD_W)
  begin : g_width_check
    $error("mcp_ctrl: word width must be 29");
  end

  mcp_state_t st;
  mcp_state_t next_st;

  logic [PIN_N-1:0]  pins;
  logic              sclk_rise;
  logic              cs_low;
  logic              cs_fall;
  logic              cs_rise;
  logic              uv;
  logic              bemf_rise;
  logic              rev_speed_signal_now;
  logic              rev_speed_signal_fall;
  logic              rev_speed_signal_edge;
  logic [REF_W-1:0]  ref_total;
  logic [CNT_W-1:0]  toggles_per_rev;
  logic [1:0]        diag_sel;

  // pin vector feeding the two-flop synchronisers
  assign pins = {I_SYNC, I_BEMF_EVENT, I_SECTOR_DATA, I_THERMAL_SHUTDOWN,
                 I_UVLO, I_SDI, I_CS_N, I_SCLK};

  // edge detection only ever looks at the second stage and its copy
  assign sclk_rise = st.sync2[P_SCLK] & ~st.prev[P_SCLK];
  assign cs_low    = ~st.sync2[P_CS_N];
  assign cs_fall   = ~st.sync2[P_CS_N] & st.prev[P_CS_N];
  assign cs_rise   = st.sync2[P_CS_N] & ~st.prev[P_CS_N];
  assign uv        = st.sync2[P_UVLO];
  assign bemf_rise = st.sync2[P_BEMF] & ~st.prev[P_BEMF];

  // active-low reference: a zero bit adds its weight
  assign ref_total = {~st.word[B_SPEED_HI:B_SPEED_LO], 4'h0};

  // poles x 3 toggles per mechanical revolution
  always_comb
  begin
    case ({st.word[B_POLE_A], st.word[B_POLE_B]})
      2'h0:    toggles_per_rev = TOGGLES_P8;
      2'h1:    toggles_per_rev = TOGGLES_P4;
      2'h2:    toggles_per_rev = TOGGLES_P16;
      2'h3:    toggles_per_rev = TOGGLES_P12;
      default: toggles_per_rev = TOGGLES_P8;
    endcase
  end

  // feedback source choice; a switch while sync is high is host misuse
  assign rev_speed_signal_now  = st.word[B_FEEDBACK] ? st.sync2[P_SECTOR]
                                         : st.rev_speed_signal_int;
  assign rev_speed_signal_edge = rev_speed_signal_now ^ st.rev_speed_signal;
  assign rev_speed_signal_fall = st.rev_speed_signal & ~rev_speed_signal_now;
  assign diag_sel  = {st.word[B_DIAG_A], st.word[B_DIAG_B]};

  // next state of the whole block
  always_comb
  begin
    next_st       = st;
    next_st.sync1 = pins;
    next_st.sync2 = st.sync1;
    next_st.prev  = st.sync2;

    // serial shift: cleared on select fall so short words zero-fill
    if (cs_fall)
      next_st.shift = '0;
    else if (cs_low && sclk_rise)
      next_st.shift = {st.shift[WORD_W-2:0], st.sync2[P_SDI]};

    // undervoltage wins over a frame end landing in the same cycle
    if (uv)
      next_st.word = '0;
    else if (cs_rise)
      next_st.word = st.shift;

    // commutation events are ignored in step mode and in sleep
    if (bemf_rise && !st.word[B_STEP_ONLY] && st.word[B_SLEEP_RUN])
    begin
      next_st.comm_toggle = ~st.comm_toggle;
      if (st.comm_cnt >= toggles_per_rev - 6'h01)
      begin
        next_st.comm_cnt = '0;
        next_st.rev_speed_signal_int = ~st.rev_speed_signal_int;
      end
      else
        next_st.comm_cnt = st.comm_cnt + 6'h01;
    end

    // reference counter restarts on every rev_speed_signal toggle, saturates at total
    next_st.rev_speed_signal = rev_speed_signal_now;
    if (rev_speed_signal_edge)
    begin
      next_st.ref_cnt  = '0;
      next_st.ref_done = 1'b0;
    end
    else if (!st.ref_done)
    begin
      next_st.ref_cnt = st.ref_cnt + 18'h00001;
      if (st.ref_cnt + 18'h00001 >= ref_total)
        next_st.ref_done = 1'b1;
    end

    // speed error on rev_speed_signal fall, judged against the reference
    next_st.err_fast = rev_speed_signal_fall & ~st.ref_done;
    next_st.err_slow = rev_speed_signal_fall & st.ref_done;

    // init holds through sleep and external control, drops on too-fast
    if (!st.word[B_SLEEP_RUN] || st.word[B_EXT_REG])
      next_st.init = 1'b1;
    else if (rev_speed_signal_fall && !st.ref_done)
      next_st.init = 1'b0;

    // diagnostic multiplexer
    case (diag_sel)
      DIAG_REV_SPEED_SIGNAL:  next_st.diag = rev_speed_signal_now;
      DIAG_THERM: next_st.diag = st.sync2[P_THERM];
      DIAG_SYNC:  next_st.diag = st.sync2[P_SYNC];
      DIAG_COMM:  next_st.diag = st.comm_toggle;
      default:    next_st.diag = 1'b0;
    endcase
  end

  // state register; reset clears the control word, hence sleep
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      st <= ST_RST;
    else
      st <= next_st;
  end

  // outputs straight from the control word and state flops
  assign O_RUN                 = st.word[B_SLEEP_RUN];
  assign O_STEP_ONLY           = st.word[B_STEP_ONLY];
  assign O_BRAKE               = st.word[B_BRAKE];
  assign O_CURRENT_LIMIT       = {st.word[B_ILIM_LO], st.word[B_ILIM_HI]};
  assign O_GAIN_SELECT         = st.word[B_GAIN];
  assign O_FEEDBACK_SOURCE     = st.word[B_FEEDBACK];
  assign O_EXTERNAL_REGULATION = st.word[B_EXT_REG];
  assign O_DIRECTION           = st.word[B_DIRECTION];
  assign O_WD_CURRENT          = {st.word[B_WD_LO], st.word[B_WD_HI]};
  assign O_SPEED_LOOP_INIT     = st.init;
  assign O_ERROR_FAST          = st.err_fast;
  assign O_ERROR_SLOW          = st.err_slow;
  assign O_REV_SPEED_SIGNAL    = st.rev_speed_signal;
  assign O_COMMUTATION_TOGGLE  = st.comm_toggle;
  assign O_DIAG_OUT            = st.diag;

  // checks on the design's own behaviour
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RSTN);

  AST_SHIFT_IN: assert property (
    cs_low && sclk_rise && !cs_fall |=>
      st.shift == {$past(st.shift[WORD_W-2:0]), $past(st.sync2[P_SDI])})
    else $error("serial bit not shifted in");

  AST_LATCH: assert property (
    cs_rise && !uv |=> st.word == $past(st.shift))
    else $error("word not latched on select rise");

  AST_WORD_HOLD: assert property (
    !cs_rise && !uv |=> $stable(st.word))
    else $error("word changed outside a frame end");

  AST_SHORT_CLEAR: assert property (
    cs_fall |=> st.shift == '0)
    else $error("shift register not cleared at select fall");

  AST_UV_SLEEP: assert property (
    uv |=> st.word == '0 && !O_RUN)
    else $error("undervoltage did not clear word");

  AST_THERM_VIEW: assert property (
    diag_sel == DIAG_THERM |=> O_DIAG_OUT == $past(st.sync2[P_THERM]))
    else $error("thermal view wrong on diagnostic pin");

  AST_EXT_INIT: assert property (
    st.word[B_EXT_REG] |=> O_SPEED_LOOP_INIT)
    else $error("init not held under external regulation");

  AST_INIT_RELEASE: assert property (
    $fell(O_SPEED_LOOP_INIT) |-> O_ERROR_FAST)
    else $error("init released without too-fast error");

  AST_ERR_ONE: assert property (
    rev_speed_signal_fall |=> O_ERROR_FAST != O_ERROR_SLOW)
    else $error("rev_speed_signal fall must give exactly one error");

  AST_REF_RESTART: assert property (
    rev_speed_signal_edge |=> st.ref_cnt == '0 && !st.ref_done)
    else $error("reference not restarted by rev_speed_signal");

  AST_STEP_MODE: assert property (
    st.word[B_STEP_ONLY] && $past(st.word[B_STEP_ONLY]) |->
      $stable(O_COMMUTATION_TOGGLE))
    else $error("commutation toggled in step mode");

  // serial port: an idle select freezes the shift register
  AST_NO_SHIFT_IDLE: assert property (
    !cs_low |=> $stable(st.shift))
    else $error("shift register moved while select high");

  // commutation events, the internal revolution signal and the sector input
  AST_COMM_TOGGLE: assert property (
    bemf_rise && !st.word[B_STEP_ONLY] && st.word[B_SLEEP_RUN] |=>
      O_COMMUTATION_TOGGLE != $past(O_COMMUTATION_TOGGLE))
    else $error("accepted event did not toggle commutation");

  AST_SLEEP_NO_COMM: assert property (
    !st.word[B_SLEEP_RUN] |=> $stable(O_COMMUTATION_TOGGLE))
    else $error("commutation toggled in sleep");

  AST_STEP_NO_REV_SPEED_SIGNAL: assert property (
    st.word[B_STEP_ONLY] |=> $stable(st.rev_speed_signal_int) && $stable(st.comm_cnt))
    else $error("event counter moved in step mode");

  AST_FB_INT: assert property (
    !st.word[B_FEEDBACK] |=> O_REV_SPEED_SIGNAL == $past(st.rev_speed_signal_int))
    else $error("internal revolution signal not selected");

  AST_FB_SECTOR: assert property (
    st.word[B_FEEDBACK] |=> O_REV_SPEED_SIGNAL == $past(st.sync2[P_SECTOR]))
    else $error("sector input not selected");

  // reference counter, speed error pulses and init in sleep
  AST_REF_COUNT: assert property (
    !rev_speed_signal_edge && !st.ref_done |=>
      st.ref_cnt == $past(st.ref_cnt) + 18'h00001)
    else $error("reference counter did not advance");

  AST_REF_DONE: assert property (
    !rev_speed_signal_edge && !st.ref_done && st.ref_cnt + 18'h00001 >= ref_total |=>
      st.ref_done)
    else $error("reference expiry missed");

  AST_REF_SAT: assert property (
    !rev_speed_signal_edge && st.ref_done |=> $stable(st.ref_cnt) && st.ref_done)
    else $error("expired reference moved");

  AST_FAST_PULSE: assert property (
    rev_speed_signal_fall && !st.ref_done |=> O_ERROR_FAST)
    else $error("early rev_speed_signal fall gave no too-fast error");

  AST_SLOW_PULSE: assert property (
    rev_speed_signal_fall && st.ref_done |=> O_ERROR_SLOW)
    else $error("late rev_speed_signal fall gave no too-slow error");

  AST_NO_ERR: assert property (
    !rev_speed_signal_fall |=> !O_ERROR_FAST && !O_ERROR_SLOW)
    else $error("speed error without rev_speed_signal fall");

  AST_SLEEP_INIT: assert property (
    !st.word[B_SLEEP_RUN] |=> O_SPEED_LOOP_INIT)
    else $error("init not held in sleep");

  // diagnostic multiplexer views
  AST_DIAG_REV_SPEED_SIGNAL: assert property (
    diag_sel == DIAG_REV_SPEED_SIGNAL |=> O_DIAG_OUT == $past(rev_speed_signal_now))
    else $error("rev_speed_signal view wrong on diagnostic pin");

  AST_DIAG_SYNC: assert property (
    diag_sel == DIAG_SYNC |=> O_DIAG_OUT == $past(st.sync2[P_SYNC]))
    else $error("sync view wrong on diagnostic pin");

  AST_DIAG_COMM: assert property (
    diag_sel == DIAG_COMM |=> O_DIAG_OUT == $past(st.comm_toggle))
    else $error("commutation view wrong on diagnostic pin");

  // main scenarios
  COV_FRAME: cover property (cs_rise && !uv ##1 O_RUN);
  COV_STEP:  cover property (st.word[B_STEP_ONLY] && bemf_rise);
  COV_FAST:  cover property (O_ERROR_FAST ##1 !O_SPEED_LOOP_INIT);
  COV_SLOW:  cover property (O_ERROR_SLOW);
  COV_SECTOR: cover property (O_FEEDBACK_SOURCE && rev_speed_signal_edge);

endmodule

// File: tb/mcp_host.sv
// Purpose: host model that frames control words onto the serial pins
// Assumes: pins step 1 ns after a system clock edge, 4 cycles per half
// Notes:   serial clock idles low; data shows the inverse of its last bit
`timescale 1ns/100ps
module mcp_host
(
  // timing reference
  input  wire logic i_clk,
  // serial pins
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_sdi
);
  // idle levels; select high so release of reset sees no frame
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi  = 1'b0;
  end

  // step off the edge so the device never races the pin change
  task automatic hold(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // one frame of n bits from w, most significant of them first
  task automatic send(input logic [28:0] w, input int n);
    hold(1);
    o_cs_n = 1'b0;
    hold(4);
    for (int i = n - 1; i >= 0; i--)
    begin
      o_sdi  = w[i];
      hold(4);
      o_sclk = 1'b1;
      hold(4);
      o_sclk = 1'b0;
    end
    hold(4);
    o_cs_n = 1'b1;
    o_sdi  = ~o_sdi; // released line must not hold a stale bit
    hold(4);
  endtask
endmodule

// File: tb/motor_ctrl_serial_config_port_bench.sv
// Purpose: self-checking bench for the serial config port
// Assumes: host model frames words; bench drives the status pins
// Notes:   expectations follow from the control word layout alone
`timescale 1ns/100ps
module motor_ctrl_serial_config_port_bench;
  logic clk = 1'b0, rstn = 1'b0, uvlo = 1'b0, therm = 1'b0;
  logic sector = 1'b0, bemf = 1'b0, sync_in = 1'b0;
  logic sclk, cs_n, sdi, run, step, brake, gain, fb, ext, dir;
  logic init, efast, eslow, rev_speed_signal, comm, diag;
  logic [1:0]  ilim, wd;
  logic [10:0] outs;
  int          fail_count = 0;
  int          comparisons = 0;
  int          nfast = 0;
  int          nslow = 0;

  assign outs = {run, step, brake, ilim, gain, fb, ext, dir, wd};

  // free-running system clock, 40 ns period
  initial
  begin
    forever #20 clk = ~clk;
  end

  mcp_host mcp_host_i (.i_clk(clk), .o_sclk(sclk), .o_cs_n(cs_n),
    .o_sdi(sdi));

  mcp_ctrl mcp_ctrl_i (.I_SYS_CLK(clk), .I_RSTN(rstn), .I_SCLK(sclk),
    .I_CS_N(cs_n), .I_SDI(sdi), .I_UVLO(uvlo),
    .I_THERMAL_SHUTDOWN(therm), .I_SECTOR_DATA(sector),
    .I_BEMF_EVENT(bemf), .I_SYNC(sync_in), .O_RUN(run),
    .O_STEP_ONLY(step), .O_BRAKE(brake), .O_CURRENT_LIMIT(ilim),
    .O_GAIN_SELECT(gain), .O_FEEDBACK_SOURCE(fb),
    .O_EXTERNAL_REGULATION(ext), .O_DIRECTION(dir), .O_WD_CURRENT(wd),
    .O_SPEED_LOOP_INIT(init), .O_ERROR_FAST(efast),
    .O_ERROR_SLOW(eslow), .O_REV_SPEED_SIGNAL(rev_speed_signal),
    .O_COMMUTATION_TOGGLE(comm), .O_DIAG_OUT(diag));

  // error outputs are one-cycle pulses, so count them every edge
  always @(posedge clk)
  begin
    if (efast === 1'b1)
      nfast++;
    if (eslow === 1'b1)
      nslow++;
  end

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // each rising edge on the event pin is one commutation event
  task automatic pulse(input int n);
    repeat (n)
    begin
      bemf = 1'b1;
      tick(3);
      bemf = 1'b0;
      tick(3);
    end
  endtask

  // decoded outputs in the order of the outs vector
  function automatic logic [10:0] dec(input logic [28:0] w);
    return {w[0], w[1], w[2], w[3], w[4], w[28], w[19], w[24], w[25],
            w[26], w[27]};
  endfunction

  // word is live 3 cycles after select rises; host already waited 4
  task automatic load(input logic [28:0] w, input int n);
    mcp_host_i.send(w, n);
    tick(2);
    check("fields", 32'(dec(w)), 32'(outs));
  endtask

  // hang guard
  initial
  begin
    #3ms;
    fail_count++;
    report_and_stop();
  end

  // main sequence
  initial
  begin
    tick(3);
    check("reset fields", 32'h0, 32'(outs));
    check("reset init", 32'h1, 32'(init));
    rstn = 1'b1;
    tick(3);
    $display("test reset done");
    for (int b = 0; b < 29; b++)
      load(29'h1 << b, 29);
    load(29'h1FFFFFFF, 29);
    load(29'h00000A5, 8);
    uvlo = 1'b1;
    tick(5);
    check("uvlo fields", 32'h0, 32'(outs));
    uvlo = 1'b0;
    tick(5);
    check("after uvlo", 32'h0, 32'(outs));
    $display("test word done");
    for (int k = 0; k < 2; k++)
    begin
      load(k ? 29'h0400000 : 29'h0800000, 29);
      therm = (k == 0);
      sync_in = (k == 1);
      tick(5);
      check("diag selected", 32'h1, 32'(diag));
      therm = (k == 1);
      sync_in = (k == 0);
      tick(5);
      check("diag unselected", 32'h0, 32'(diag));
    end
    therm = 1'b0;
    load(29'h0080000, 29);
    sector = 1'b1;
    tick(5);
    check("sector rev_speed_signal", 32'h3, 32'({rev_speed_signal, diag}));
    sector = 1'b0;
    tick(5);
    check("sector fast", 32'h1, 32'(nfast));
    $display("test diag done");
    load(29'h0E00001, 29);
    pulse(1);
    check("comm toggle", 32'h3, 32'({comm, diag}));
    pulse(11);
    check("rev_speed_signal after 12", 32'h1, 32'(rev_speed_signal));
    pulse(12);
    check("fast count", 32'h2, 32'(nfast));
    check("init released", 32'h0, 32'(init));
    load(29'h1E00001, 29);
    check("init external", 32'h1, 32'(init));
    load(29'h027FFE1, 29);
    pulse(24);
    check("slow count", 32'h1, 32'(nslow));
    check("fast unchanged", 32'h2, 32'(nfast));
    check("init held", 32'h1, 32'(init));
    load(29'h0E00003, 29);
    pulse(1);
    check("step comm", 32'h0, 32'({comm, diag}));
    load(29'h0E00000, 29);
    pulse(1);
    check("sleep comm", 32'h0, 32'({comm, diag}));
    $display("test speed done");
    load(29'h1FFFFFFF, 29);
    rstn = 1'b0;
    tick(2);
    check("mid reset fields", 32'h0, 32'(outs));
    check("mid reset init", 32'h1, 32'(init));
    rstn = 1'b1;
    tick(3);
    load(29'h00000A5, 8);
    $display("test mid reset done");
    report_and_stop();
  end
endmodule
